// *** hw/gst_pkg.sv ***
package gst_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] GST_OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] GST_OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] GST_OFS_GATE_CTRL = 8'h08;
  localparam logic [7:0] GST_OFS_CTRL = 8'h0C;
  localparam logic [7:0] GST_OFS_FLAGS = 8'h10;
  localparam logic [7:0] GST_OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] GST_OFS_CMP_STAT = 8'h18;
  // Gate control fields
  localparam int GST_GC_GATE_EN = 7;
  localparam int GST_GC_POL = 6;
  localparam int GST_GC_TOGGLE = 5;
  localparam int GST_GC_SPM = 4;
  localparam int GST_GC_GO = 3;
  localparam int GST_GC_VAL = 2;
  localparam int GST_GC_SS_HI = 1;
  localparam logic [1:0] GST_SS_PIN = 2'h0;
  localparam logic [1:0] GST_SS_MATCH = 2'h1;
  localparam logic [1:0] GST_SS_CMP1 = 2'h2;
  localparam logic [1:0] GST_SS_CMP2 = 2'h3;
  // Control fields
  localparam int GST_CT_CS_HI = 7;
  localparam int GST_CT_PS_HI = 5;
  localparam int GST_CT_RD16 = 1;
  localparam int GST_CT_ON = 0;
  localparam logic [1:0] GST_CS_INSTR = 2'h0;
  localparam logic [1:0] GST_CS_SYS = 2'h1;
  localparam logic [1:0] GST_CS_EXT = 2'h2;
  // Comparator status bits
  localparam int GST_CMP1_BIT = 5;
  localparam int GST_CMP2_BIT = 6;
  // Flag and enable layout, special event compare mode
  localparam int GST_GATE_FLAG_BIT = 0;
  localparam int GST_OVF_BIT_LOW = 1;
  localparam int GST_OVF_BIT_HIGH = 3;
  localparam logic [3:0] GST_CMP_MODE_SPECIAL = 4'hB;
  // Reset values and count limit
  localparam logic [7:0] GST_RST_GATE_CTRL = 8'h00;
  localparam logic [7:0] GST_RST_CTRL = 8'h00;
  localparam logic [15:0] GST_RST_COUNT = 16'h0000;
  localparam logic [15:0] GST_COUNT_MAX = 16'hFFFF;
  // Core clocks per instruction cycle
  localparam int GST_INSTR_DIV = 4;
endpackage

// *** hw/gst_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module gst_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level accepted only once two stages agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign q = q_ff;
endmodule // gst_sync
`default_nettype wire

// *** hw/gst_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module gst_timer
  import gst_pkg::*;
#(
  parameter int INSTANCE = 0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gate_input_pin,
  input wire logic ext_clk_pin,
  input wire logic [7:0] comparator_status,
  input wire logic companion_match,
  input wire logic compare_assigned,
  input wire logic [3:0] compare_unit_mode_field,
  input wire logic special_event_trigger,
  output logic overflow_irq,
  output logic gate_event_irq
);
  localparam int OVF_BIT = (INSTANCE == 2) ? GST_OVF_BIT_HIGH : GST_OVF_BIT_LOW;

  if (INSTANCE < 0 || INSTANCE > 2) begin : g_bad_instance
    $error("INSTANCE must be 0, 1 or 2");
  end

  logic [7:0] gate_ctrl_ff;
  logic [7:0] ctrl_ff;
  logic [15:0] count_ff;
  logic [7:0] high_buf_ff;
  logic [7:0] flags_ff;
  logic [7:0] irq_en_ff;
  logic [31:0] prdata_ff;
  logic [1:0] instr_div_ff;
  logic [2:0] pre_ff;
  logic [1:0] match_cnt_ff;
  logic match_gate_ff;
  logic gate_act_ff;
  logic toggle_ff;
  logic gate_t_ff;
  logic armed_ff;
  logic gate_level_status_ff;
  logic ext_prev_ff;

  logic [3:0] async_in;
  logic [3:0] async_sync;

  // Pin, external clock and comparator levels arrive from other domains
  assign async_in = {comparator_status[GST_CMP2_BIT], comparator_status[GST_CMP1_BIT],
                     ext_clk_pin, gate_input_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      gst_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d(async_in[gi]),
        .q(async_sync[gi])
      );
    end
  endgenerate
  wire logic pin_s = async_sync[0];
  wire logic ext_s = async_sync[1];
  wire logic cmp1_s = async_sync[2];
  wire logic cmp2_s = async_sync[3];

  // Field views
  wire logic gate_en = gate_ctrl_ff[GST_GC_GATE_EN];
  wire logic polarity = gate_ctrl_ff[GST_GC_POL];
  wire logic toggle_en = gate_ctrl_ff[GST_GC_TOGGLE];
  wire logic spm_en = gate_ctrl_ff[GST_GC_SPM];
  wire logic go_done = gate_ctrl_ff[GST_GC_GO];
  wire logic [1:0] src_sel = gate_ctrl_ff[GST_GC_SS_HI -: 2];
  wire logic timer_on = ctrl_ff[GST_CT_ON];
  wire logic rd16 = ctrl_ff[GST_CT_RD16];
  wire logic [1:0] clk_sel = ctrl_ff[GST_CT_CS_HI -: 2];
  wire logic [1:0] pre_sel = ctrl_ff[GST_CT_PS_HI -: 2];

  // APB decode; zero wait states
  wire logic setup_ph = psel & ~penable;
  wire logic access = psel & penable;
  wire logic wr = access & pwrite;
  wire logic rd = access & ~pwrite;
  logic mapped;
  always_comb begin
    case (paddr)
      GST_OFS_COUNT_LOW, GST_OFS_COUNT_HIGH, GST_OFS_GATE_CTRL, GST_OFS_CTRL,
      GST_OFS_FLAGS, GST_OFS_IRQ_EN, GST_OFS_CMP_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  wire logic wr_low = wr & (paddr == GST_OFS_COUNT_LOW);
  wire logic wr_high = wr & (paddr == GST_OFS_COUNT_HIGH);
  wire logic wr_gc = wr & (paddr == GST_OFS_GATE_CTRL);

  // Instruction cycle divider
  logic instr_tick;
  assign instr_tick = (instr_div_ff == 2'(GST_INSTR_DIV - 1));
  always_ff @(posedge core_clk) begin
    if (rst) begin
      instr_div_ff <= 2'h0;
    end else begin
      instr_div_ff <= instr_tick ? 2'h0 : instr_div_ff + 2'h1;
    end
  end

  // Clock source and prescaler
  logic ext_rise;
  logic src_tick;
  logic tick;
  assign ext_rise = ext_s & ~ext_prev_ff;
  always_comb begin
    case (clk_sel)
      GST_CS_INSTR: src_tick = instr_tick;
      GST_CS_SYS: src_tick = 1'b1;
      GST_CS_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
  end
  always_comb begin
    case (pre_sel)
      2'h0: tick = src_tick;
      2'h1: tick = src_tick & pre_ff[0];
      2'h2: tick = src_tick & (&pre_ff[1:0]);
      default: tick = src_tick & (&pre_ff);
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_prev_ff <= 1'b0;
      pre_ff <= 3'h0;
    end else begin
      ext_prev_ff <= ext_s;
      // Prescaler restarts on a low byte write
      if (wr_low) begin
        pre_ff <= 3'h0;
      end else if (src_tick & timer_on) begin
        pre_ff <= pre_ff + 3'h1;
      end
    end
  end

  // Companion match pulse, one instruction cycle long
  always_ff @(posedge core_clk) begin
    if (rst) begin
      match_cnt_ff <= 2'h0;
      match_gate_ff <= 1'b0;
    end else if (companion_match) begin
      match_cnt_ff <= 2'(GST_INSTR_DIV - 1);
      match_gate_ff <= 1'b1;
    end else if (match_cnt_ff != 2'h0) begin
      match_cnt_ff <= match_cnt_ff - 2'h1;
    end else begin
      match_gate_ff <= 1'b0;
    end
  end

  // Source select and polarity
  logic gate_raw;
  logic gate_act;
  always_comb begin
    case (src_sel)
      GST_SS_PIN: gate_raw = pin_s;
      GST_SS_MATCH: gate_raw = match_gate_ff;
      GST_SS_CMP1: gate_raw = cmp1_s;
      GST_SS_CMP2: gate_raw = cmp2_s;
      default: gate_raw = 1'b0;
    endcase
  end
  assign gate_act = (gate_raw == polarity);

  // Toggle stage
  logic act_rise;
  logic gate_t;
  assign act_rise = gate_act & ~gate_act_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_act_ff <= 1'b0;
      toggle_ff <= 1'b0;
    end else begin
      gate_act_ff <= gate_act;
      if (!toggle_en) begin
        toggle_ff <= 1'b0;
      end else if (act_rise) begin
        toggle_ff <= ~toggle_ff;
      end
    end
  end
  assign gate_t = toggle_en ? toggle_ff : gate_act;

  // Single pulse stage
  logic t_rise;
  logic t_fall;
  logic nxt_armed;
  logic nxt_gate_val;
  assign t_rise = gate_t & ~gate_t_ff;
  assign t_fall = ~gate_t & gate_t_ff;
  // Toggle output feeds this stage, so combined mode spans one full cycle
  assign nxt_armed = spm_en & ((armed_ff & ~t_fall) | (go_done & t_rise));
  assign nxt_gate_val = spm_en ? (gate_t & nxt_armed) : gate_t;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_t_ff <= 1'b0;
      armed_ff <= 1'b0;
      gate_level_status_ff <= 1'b0;
    end else begin
      gate_t_ff <= gate_t;
      armed_ff <= nxt_armed;
      gate_level_status_ff <= nxt_gate_val;
    end
  end

  // Gate control register; go/done cleared by hardware
  logic go_hw_clr;
  assign go_hw_clr = armed_ff & t_fall;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_ctrl_ff <= GST_RST_GATE_CTRL;
    end else if (wr_gc) begin
      gate_ctrl_ff[7:4] <= pwdata[7:4];
      gate_ctrl_ff[1:0] <= pwdata[1:0];
      // A fresh arm from software outranks a completing pulse
      gate_ctrl_ff[GST_GC_GO] <= pwdata[GST_GC_SPM] &
        (pwdata[GST_GC_GO] | (go_done & ~go_hw_clr));
    end else if (go_hw_clr) begin
      gate_ctrl_ff[GST_GC_GO] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_ff <= GST_RST_CTRL;
    end else if (wr & (paddr == GST_OFS_CTRL)) begin
      ctrl_ff <= pwdata[7:0];
    end
  end

  // Count
  logic count_en;
  logic overflow;
  logic trig;
  assign count_en = tick & timer_on & (~gate_en | gate_level_status_ff);
  assign overflow = count_en & (count_ff == GST_COUNT_MAX);
  assign trig = special_event_trigger & compare_assigned &
                (compare_unit_mode_field == GST_CMP_MODE_SPECIAL);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_ff <= GST_RST_COUNT;
    end else if (wr_low) begin
      count_ff <= {rd16 ? high_buf_ff : count_ff[15:8], pwdata[7:0]};
    end else if (wr_high & ~rd16) begin
      count_ff[15:8] <= pwdata[7:0];
    end else if (trig) begin
      count_ff <= GST_RST_COUNT;
    end else if (count_en) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // High byte buffer for 16-bit access
  always_ff @(posedge core_clk) begin
    if (rst) begin
      high_buf_ff <= 8'h00;
    end else if (wr_high & rd16) begin
      high_buf_ff <= pwdata[7:0];
    end else if (rd & (paddr == GST_OFS_COUNT_LOW) & rd16) begin
      high_buf_ff <= count_ff[15:8];
    end
  end

  // Flags: write one to clear, a hardware set wins
  logic gate_fall;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  assign gate_fall = ~nxt_gate_val & gate_level_status_ff;
  always_comb begin
    flag_set = 8'h00;
    flag_set[GST_GATE_FLAG_BIT] = gate_fall;
    flag_set[OVF_BIT] = overflow;
  end
  assign flag_clr = (wr & (paddr == GST_OFS_FLAGS)) ? pwdata[7:0] : 8'h00;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_ff <= 8'h00;
    end else begin
      flags_ff <= flag_set | (flags_ff & ~flag_clr);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_en_ff <= 8'h00;
    end else if (wr & (paddr == GST_OFS_IRQ_EN)) begin
      irq_en_ff <= pwdata[7:0];
    end
  end

  wire logic [7:0] flag_mask = 8'(1 << OVF_BIT) | 8'(1 << GST_GATE_FLAG_BIT);

  assign gate_event_irq = flags_ff[GST_GATE_FLAG_BIT] & irq_en_ff[GST_GATE_FLAG_BIT];
  assign overflow_irq = flags_ff[OVF_BIT] & irq_en_ff[OVF_BIT];

  // Read data latched in the setup phase
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr)
      GST_OFS_COUNT_LOW: rd_byte = count_ff[7:0];
      GST_OFS_COUNT_HIGH: rd_byte = rd16 ? high_buf_ff : count_ff[15:8];
      GST_OFS_GATE_CTRL: rd_byte = {gate_ctrl_ff[7:3], gate_level_status_ff,
                                    gate_ctrl_ff[1:0]};
      GST_OFS_CTRL: rd_byte = ctrl_ff;
      GST_OFS_FLAGS: rd_byte = flags_ff & flag_mask;
      GST_OFS_IRQ_EN: rd_byte = irq_en_ff & flag_mask;
      GST_OFS_CMP_STAT: rd_byte = {1'b0, cmp2_s, cmp1_s, 5'h00};
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_ff <= {24'h00_0000, rd_byte};
    end
  end
  assign prdata = prdata_ff;
endmodule // gst_timer
`default_nettype wire

// *** testbench/gst_timer_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module gst_timer_asserts
  import gst_pkg::*;
#(
  parameter int INSTANCE = 0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gate_input_pin,
  input wire logic ext_clk_pin,
  input wire logic [7:0] comparator_status,
  input wire logic companion_match,
  input wire logic compare_assigned,
  input wire logic [3:0] compare_unit_mode_field,
  input wire logic special_event_trigger,
  input wire logic overflow_irq,
  input wire logic gate_event_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic fl_wr;
  logic [31:0] keep_mask;
  assign acc = psel && penable;
  // Writes to flags or enables are the only legal way an interrupt drops
  assign fl_wr = acc && pwrite && (paddr == GST_OFS_FLAGS || paddr == GST_OFS_IRQ_EN);
  assign keep_mask = 32'h1 | (32'h1 << ((INSTANCE == 2) ? GST_OVF_BIT_HIGH : GST_OVF_BIT_LOW));
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_slverr_unmapped: assert property (acc && paddr > GST_OFS_CMP_STAT |-> pslverr)
    else $error("no slave error on unmapped access");
  a_slverr_idle: assert property (!acc |-> !pslverr)
    else $error("slave error outside access");
  a_read_unmapped: assert property (acc && !pwrite && paddr > GST_OFS_CMP_STAT |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ((!psel || penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_ovf_sticky: assert property (overflow_irq && !fl_wr |=> overflow_irq)
    else $error("overflow interrupt dropped by itself");
  a_gate_sticky: assert property (gate_event_irq && !fl_wr |=> gate_event_irq)
    else $error("gate interrupt dropped by itself");
  a_flag_layout: assert property (acc && !pwrite &&
    (paddr == GST_OFS_FLAGS || paddr == GST_OFS_IRQ_EN) |-> (prdata & ~keep_mask) == 32'h0)
    else $error("flag bit outside layout");
  a_reset_quiet: assert property ($fell(rst) |-> !overflow_irq && !gate_event_irq)
    else $error("interrupt active after reset");
  cover property (overflow_irq);
  cover property (gate_event_irq);
  cover property (acc && pslverr);
endmodule // gst_timer_asserts
bind gst_timer gst_timer_asserts #(.INSTANCE(INSTANCE)) u_chk (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_input_pin(gate_input_pin),
  .ext_clk_pin(ext_clk_pin), .comparator_status(comparator_status),
  .companion_match(companion_match), .compare_assigned(compare_assigned),
  .compare_unit_mode_field(compare_unit_mode_field),
  .special_event_trigger(special_event_trigger), .overflow_irq(overflow_irq),
  .gate_event_irq(gate_event_irq));
`default_nettype wire

// *** testbench/gst_companion_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gst_companion_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] period,
  output logic companion_match
);
  // Companion counts at instruction rate, a quarter of the core clock
  logic [1:0] div_ff;
  logic [7:0] cnt_ff;
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      div_ff <= 2'h0;
      cnt_ff <= 8'h00;
      companion_match <= 1'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
      companion_match <= 1'h0;
      if (div_ff == 2'h3) begin
        cnt_ff <= (cnt_ff == period) ? 8'h00 : cnt_ff + 8'h01;
        companion_match <= (cnt_ff == period);
      end
    end
  end
endmodule // gst_companion_model
`default_nettype wire

// *** testbench/test_gated_sixteen_bit_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_gated_sixteen_bit_timer;
  import gst_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, gpin, cmatch, cassign, trig;
  logic run, arm, slv, ovf_irq, gev_irq;
  logic [7:0] paddr, cstat;
  logic [3:0] cmode;
  logic [31:0] pwdata, prdata, rdat;
  int n_fail, total_checks, n_match, cycles, c1;
  gst_timer #(.INSTANCE(2)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_input_pin(gpin), .ext_clk_pin(1'h0),
    .comparator_status(cstat), .companion_match(cmatch), .compare_assigned(cassign),
    .compare_unit_mode_field(cmode), .special_event_trigger(trig),
    .overflow_irq(ovf_irq), .gate_event_irq(gev_irq));
  gst_companion_model far (.core_clk(core_clk), .rst(rst), .run(run), .period(8'h03),
    .companion_match(cmatch));
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    n_match += (cmatch === 1'h1);
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One idle cycle after each transfer keeps drivers from double assignment
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'h1;
    trig <= arm;
    @(posedge core_clk);
    while (pready !== 1'h1) @(posedge core_clk);
    rdat = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    trig <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'h1, d);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string nm);
    apb(a, 1'h0, 8'h00);
    chk(nm, {24'h000000, e}, rdat & {24'h000000, m});
  endtask
  task automatic src(input int s, input logic v);
    if (s == 0) gpin <= v;
    if (s == 2) cstat[GST_CMP1_BIT] <= v;
    if (s == 3) cstat[GST_CMP2_BIT] <= v;
  endtask
  task automatic gp(input int n);
    gpin <= 1'h1;
    cyc(n);
    gpin <= 1'h0;
    cyc(n);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst, psel, penable, pwrite, gpin, cassign, trig, run, arm} = 9'h100;
    paddr = 8'h00;
    pwdata = 32'h0;
    cstat = 8'h00;
    cmode = 4'h0;
    cyc(5);
    rst <= 1'h0;
    cyc(1);
    for (int i = 0; i < 7; i++) rdc(8'(4 * i), 8'hFB, 8'h00, "reset value");
    wr(8'h1C, 8'hFF);
    chk("pslverr", 32'h1, {31'h0, slv});
    rdc(8'h1C, 8'hFF, 8'h00, "unmapped read");
    wr(GST_OFS_COUNT_LOW, 8'hF0);
    wr(GST_OFS_COUNT_HIGH, 8'hFF);
    wr(GST_OFS_IRQ_EN, 8'h09);
    wr(GST_OFS_CTRL, 8'h41);
    cyc(30);
    wr(GST_OFS_CTRL, 8'h40);
    rdc(GST_OFS_FLAGS, 8'h08, 8'h08, "overflow flag");
    chk("overflow irq", 32'h1, {31'h0, ovf_irq});
    rdc(GST_OFS_COUNT_HIGH, 8'hFF, 8'h00, "count wrap");
    wr(GST_OFS_FLAGS, 8'h08);
    rdc(GST_OFS_FLAGS, 8'h08, 8'h00, "flag clear");
    cassign <= 1'h1;
    cmode <= 4'hA;
    // Count parked at the top so a trigger that wrapped would raise the flag
    wr(GST_OFS_COUNT_HIGH, 8'hFF);
    wr(GST_OFS_COUNT_LOW, 8'hFF);
    arm = 1'h1;
    wr(GST_OFS_IRQ_EN, 8'h09);
    rdc(GST_OFS_COUNT_LOW, 8'hFF, 8'hFF, "other mode trigger");
    cmode <= GST_CMP_MODE_SPECIAL;
    wr(GST_OFS_IRQ_EN, 8'h09);
    rdc(GST_OFS_COUNT_LOW, 8'hFF, 8'h00, "trigger reset");
    rdc(GST_OFS_COUNT_HIGH, 8'hFF, 8'h00, "trigger reset high");
    rdc(GST_OFS_FLAGS, 8'h08, 8'h00, "trigger flag");
    wr(GST_OFS_COUNT_LOW, 8'h56);
    arm = 1'h0;
    rdc(GST_OFS_COUNT_LOW, 8'hFF, 8'h56, "write beats trigger");
    run <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      wr(GST_OFS_GATE_CTRL, 8'h40 | 8'(s));
      cyc(10);
      wr(GST_OFS_FLAGS, 8'h01);
      if (s != 1) begin
        for (int o = 0; o < 4; o++) if (o != s) src(o, 1'h1);
        cyc(10);
        for (int o = 0; o < 4; o++) src(o, 1'h0);
        cyc(10);
        rdc(GST_OFS_FLAGS, 8'h01, 8'h00, "unselected source");
        src(s, 1'h1);
        cyc(10);
        rdc(GST_OFS_GATE_CTRL, 8'h04, 8'h04, "gate level");
        src(s, 1'h0);
      end
      cyc(40);
      rdc(GST_OFS_FLAGS, 8'h01, 8'h01, "gate event flag");
      chk("gate event irq", 32'h1, {31'h0, gev_irq});
    end
    run <= 1'h0;
    wr(GST_OFS_COUNT_LOW, 8'h00);
    wr(GST_OFS_GATE_CTRL, 8'hC1);
    wr(GST_OFS_CTRL, 8'h01);
    n_match = 0;
    run <= 1'h1;
    cyc(200);
    run <= 1'h0;
    cyc(10);
    wr(GST_OFS_CTRL, 8'h00);
    rdc(GST_OFS_COUNT_LOW, 8'hFF, 8'(n_match), "match gated count");
    // Pulse span is judged from zero, not from the match count left behind
    wr(GST_OFS_COUNT_LOW, 8'h00);
    wr(GST_OFS_GATE_CTRL, 8'hD8);
    wr(GST_OFS_CTRL, 8'h41);
    gp(20);
    apb(GST_OFS_COUNT_LOW, 1'h0, 8'h00);
    c1 = rdat;
    chk("pulse span", 32'h1, {31'h0, c1 > 15 && c1 < 26});
    gp(20);
    rdc(GST_OFS_COUNT_LOW, 8'hFF, 8'(c1), "held after done");
    rdc(GST_OFS_GATE_CTRL, 8'h08, 8'h00, "go cleared");
    wr(GST_OFS_GATE_CTRL, 8'hD8);
    wr(GST_OFS_GATE_CTRL, 8'hC8);
    rdc(GST_OFS_GATE_CTRL, 8'h08, 8'h00, "go dropped");
    wr(GST_OFS_CTRL, 8'h40);
    wr(GST_OFS_COUNT_LOW, 8'h00);
    wr(GST_OFS_GATE_CTRL, 8'hF8);
    wr(GST_OFS_CTRL, 8'h41);
    repeat (3) gp(20);
    wr(GST_OFS_CTRL, 8'h40);
    apb(GST_OFS_COUNT_LOW, 1'h0, 8'h00);
    c1 = rdat;
    chk("toggle span", 32'h1, {31'h0, c1 > 35 && c1 < 46});
    tally_and_finish();
  end
endmodule // test_gated_sixteen_bit_timer
`default_nettype wire
